// ### logic/rspr_router.sv
// status, data and bit clock routing onto six general-purpose pins
`timescale 1ns/1ps

module rspr_router (
	input wire logic clk,
	input wire logic srst,
	input wire logic link_clk,
	input wire logic [7:0] pin_route_cfg_a,
	input wire logic [7:0] pin_route_cfg_b,
	input wire rspr_pkg::rspr_state_t op_state,
	input wire logic packet_mode,
	input wire logic bit_sync_en,
	input wire rspr_pkg::rspr_flags_t flags,
	input wire logic ref_clock_output,
	input wire logic demod_raw,
	input wire logic demod_bit,
	output logic gp_pin_0,
	output logic gp_pin_1,
	output logic gp_pin_2,
	output logic gp_pin_3,
	output logic gp_pin_4,
	output logic gp_pin_5,
	output rspr_pkg::rspr_fifo_bit_t fifo_wr,
	output logic fifo_clear
);

	// link-domain reset held until the link side echoes it; srst may be shorter than a link period
	logic link_srst;
	logic link_ack_s;
	logic link_rst_req_r;
	logic bit_hold_r;
	logic bit_tgl_r;

	always_ff @(posedge clk)
	begin
		if (srst)
			link_rst_req_r <= 1'b1;
		else if (link_ack_s)
			link_rst_req_r <= 1'b0;
	end

	rspr_sync2 #(.W(1)) u_link_ack (.clk(clk), .d(link_srst), .q(link_ack_s));
	rspr_sync2 #(.W(1)) u_link_rst (
		.clk(link_clk),
		.d(link_rst_req_r),
		.q(link_srst)
	);

	// bit is held a full link period, so it is stable when the toggle lands
	always_ff @(posedge link_clk)
	begin
		if (link_srst)
		begin
			bit_hold_r <= 1'b0;
			bit_tgl_r <= 1'b0;
		end
		else
		begin
			bit_hold_r <= demod_bit;
			bit_tgl_r <= ~bit_tgl_r;
		end
	end

	logic raw_s;
	logic tgl_s;
	logic tgl_d_r;
	logic bit_evt;

	rspr_sync2 #(.W(2)) u_sync (
		.clk(clk),
		.d({demod_raw, bit_tgl_r}),
		.q({raw_s, tgl_s})
	);

	assign bit_evt = tgl_s ^ tgl_d_r;

	wire is_rx = (op_state == rspr_pkg::RSPR_RECEIVE);
	wire bitsync_on = bit_sync_en | packet_mode;

	// retimed data and recovered bit clock
	logic bit_data_r;
	logic dclk_r;
	logic [rspr_pkg::DCLK_CNT_W-1:0] dclk_cnt_r;

	// bit clock falls with every new bit and rises after a fixed low phase
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tgl_d_r <= 1'b0;
			bit_data_r <= 1'b0;
			dclk_r <= 1'b0;
			dclk_cnt_r <= rspr_pkg::DCLK_CNT_ZERO;
		end
		else
		begin
			tgl_d_r <= tgl_s;
			if (bit_evt)
			begin
				bit_data_r <= bit_hold_r;
				dclk_r <= 1'b0;
				dclk_cnt_r <= rspr_pkg::DCLK_LOW_CYC - rspr_pkg::DCLK_CNT_ONE;
			end
			else if (dclk_cnt_r != rspr_pkg::DCLK_CNT_ZERO)
				dclk_cnt_r <= dclk_cnt_r - rspr_pkg::DCLK_CNT_ONE;
			else
				dclk_r <= 1'b1;
		end
	end

	wire data_src = bitsync_on ? bit_data_r : raw_s;
	wire dclk_src = bitsync_on & dclk_r;

	// packet data window: ready rise opens it, body available rise closes it
	logic win_r;
	logic rdy_d_r;
	logic body_d_r;
	wire rdy_rise = flags.receiver_ready_flag & ~rdy_d_r;
	wire body_rise = flags.packet_body_available & ~body_d_r;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			win_r <= 1'b0;
			rdy_d_r <= 1'b0;
			body_d_r <= 1'b0;
		end
		else
		begin
			rdy_d_r <= flags.receiver_ready_flag;
			body_d_r <= flags.packet_body_available;
			if (!is_rx || body_rise)
				win_r <= 1'b0;
			else if (rdy_rise)
				win_r <= 1'b1;
		end
	end

	wire pin_data = packet_mode ? (data_src & win_r) : data_src;

	// queue write port and clear on entry to receive only
	logic was_rx_r;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			fifo_wr <= '0;
			fifo_clear <= 1'b0;
			was_rx_r <= 1'b0;
		end
		else
		begin
			was_rx_r <= is_rx;
			fifo_wr.valid <= bit_evt & packet_mode & is_rx;
			fifo_wr.bit_value <= bit_hold_r;
			fifo_clear <= is_rx & ~was_rx_r;
		end
	end

	// code of one pin from the two mapping ports
	function automatic logic [1:0] code_of(int pin, logic [7:0] cfg_a, logic [7:0] cfg_b);
		case (pin)
			0: code_of = cfg_a[rspr_pkg::CFG_A_PIN0_LSB +: rspr_pkg::CODE_W];
			1: code_of = cfg_a[rspr_pkg::CFG_A_PIN1_LSB +: rspr_pkg::CODE_W];
			2: code_of = cfg_a[rspr_pkg::CFG_A_PIN2_LSB +: rspr_pkg::CODE_W];
			3: code_of = cfg_a[rspr_pkg::CFG_A_PIN3_LSB +: rspr_pkg::CODE_W];
			4: code_of = cfg_b[rspr_pkg::CFG_B_PIN4_LSB +: rspr_pkg::CODE_W];
			default: code_of = cfg_b[rspr_pkg::CFG_B_PIN5_LSB +: rspr_pkg::CODE_W];
		endcase
	endfunction

	// one row of sources, pin 5 leftmost, for a mode, state and code
	function automatic logic [rspr_pkg::ROW_W-1:0] route_row(logic pkt, rspr_pkg::rspr_state_t st,
		logic [1:0] code);
		logic rx;
		logic fs;
		logic slp;
		rspr_pkg::rspr_src_t ck;
		rspr_pkg::rspr_src_t lk;
		rx = (st == rspr_pkg::RSPR_RECEIVE);
		fs = (st == rspr_pkg::RSPR_SYNTHESIZER_STATE);
		slp = (st == rspr_pkg::RSPR_SLEEP);
		ck = slp ? rspr_pkg::SRC_LOW : rspr_pkg::SRC_CLK;
		lk = fs ? rspr_pkg::SRC_PLL : rspr_pkg::SRC_LOW;
		route_row = {rspr_pkg::NUM_PINS{rspr_pkg::SRC_LOW}};
		if (!pkt && rx)
		begin
			case (code)
				rspr_pkg::CODE_00: route_row = {rspr_pkg::SRC_CLK, rspr_pkg::SRC_TO, rspr_pkg::SRC_RSSI,
					rspr_pkg::SRC_DATA, rspr_pkg::SRC_DCLK, rspr_pkg::SRC_SYNC};
				rspr_pkg::CODE_01: route_row = {rspr_pkg::SRC_RSSI, rspr_pkg::SRC_RR, rspr_pkg::SRC_RR,
					rspr_pkg::SRC_DATA, rspr_pkg::SRC_RR, rspr_pkg::SRC_TO};
				rspr_pkg::CODE_10: route_row = {rspr_pkg::SRC_LB, rspr_pkg::SRC_SYNC, rspr_pkg::SRC_AM,
					rspr_pkg::SRC_DATA, rspr_pkg::SRC_LB, rspr_pkg::SRC_RSSI};
				default: route_row = {rspr_pkg::SRC_MR, rspr_pkg::SRC_PLL, rspr_pkg::SRC_TO,
					rspr_pkg::SRC_DATA, rspr_pkg::SRC_SYNC, rspr_pkg::SRC_MR};
			endcase
		end
		else if (!pkt)
		begin
			case (code)
				rspr_pkg::CODE_00: route_row = {ck, rspr_pkg::SRC_LOW, rspr_pkg::SRC_LOW,
					rspr_pkg::SRC_LOW, rspr_pkg::SRC_LOW, lk};
				rspr_pkg::CODE_01: route_row = {rspr_pkg::NUM_PINS{rspr_pkg::SRC_LOW}};
				rspr_pkg::CODE_10: route_row = {rspr_pkg::SRC_LB, rspr_pkg::SRC_LB, rspr_pkg::SRC_AM,
					rspr_pkg::SRC_LOW, rspr_pkg::SRC_LB, rspr_pkg::SRC_LB};
				default: route_row = {rspr_pkg::SRC_MR, lk, rspr_pkg::SRC_LOW,
					rspr_pkg::SRC_LOW, lk, rspr_pkg::SRC_MR};
			endcase
		end
		else if (rx)
		begin
			case (code)
				rspr_pkg::CODE_00: route_row = {rspr_pkg::SRC_CLK, rspr_pkg::SRC_TO, rspr_pkg::SRC_FF,
					rspr_pkg::SRC_FNE, rspr_pkg::SRC_FL, rspr_pkg::SRC_CRC};
				rspr_pkg::CODE_01: route_row = {rspr_pkg::SRC_DATA, rspr_pkg::SRC_RSSI, rspr_pkg::SRC_RSSI,
					rspr_pkg::SRC_DATA, rspr_pkg::SRC_FF, rspr_pkg::SRC_PR};
				rspr_pkg::CODE_10: route_row = {rspr_pkg::SRC_LB, rspr_pkg::SRC_RR, rspr_pkg::SRC_SYNC,
					rspr_pkg::SRC_LB, rspr_pkg::SRC_FNE, rspr_pkg::SRC_SYNC};
				default: route_row = {rspr_pkg::SRC_MR, rspr_pkg::SRC_PLL, rspr_pkg::SRC_PLL,
					rspr_pkg::SRC_AM, rspr_pkg::SRC_TO, rspr_pkg::SRC_RSSI};
			endcase
		end
		else
		begin
			case (code)
				rspr_pkg::CODE_00: route_row = {ck, rspr_pkg::SRC_LOW, rspr_pkg::SRC_FF,
					rspr_pkg::SRC_FNE, rspr_pkg::SRC_FL, rspr_pkg::SRC_LOW};
				rspr_pkg::CODE_01: route_row = {rspr_pkg::SRC_LOW, rspr_pkg::SRC_LOW, rspr_pkg::SRC_LOW,
					rspr_pkg::SRC_LOW, rspr_pkg::SRC_FF, rspr_pkg::SRC_LOW};
				rspr_pkg::CODE_10: route_row = {rspr_pkg::SRC_LB, rspr_pkg::SRC_LB, rspr_pkg::SRC_LB,
					rspr_pkg::SRC_LB, rspr_pkg::SRC_FNE, rspr_pkg::SRC_LB};
				default: route_row = {rspr_pkg::SRC_MR, lk, lk, rspr_pkg::SRC_AM, lk, lk};
			endcase
		end
	endfunction

	// queue flags pass untouched; their meaning is owned by the queue
	wire [rspr_pkg::NUM_SRC-1:0] src_vec = {
		flags.packet_body_available,
		flags.checksum_pass_flag,
		flags.queue_level_flag,
		flags.queue_nonempty_flag,
		flags.queue_full_flag,
		flags.synth_lock_flag,
		flags.op_state_ready,
		flags.auto_sequencer_active,
		flags.battery_low_flag,
		flags.receiver_ready_flag,
		flags.sync_match_flag,
		dclk_src,
		pin_data,
		flags.signal_strength_flag,
		flags.rx_time_limit_flag,
		ref_clock_output,
		1'b0
	};

	logic [rspr_pkg::NUM_PINS-1:0] pin_r;
	wire [rspr_pkg::NUM_PINS-1:0] pin_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < rspr_pkg::NUM_PINS; gi++)
		begin : g_pin
			wire [1:0] code = code_of(gi, pin_route_cfg_a, pin_route_cfg_b);
			wire [rspr_pkg::ROW_W-1:0] row = route_row(packet_mode, op_state, code);
			wire [rspr_pkg::SRC_W-1:0] sel = row[gi*rspr_pkg::SRC_W +: rspr_pkg::SRC_W];
			assign pin_nxt[gi] = src_vec[sel];
		end
	endgenerate

	// one register stage per pin keeps unchanged pins glitch free
	always_ff @(posedge clk)
	begin
		if (srst)
			pin_r <= '0;
		else
			pin_r <= pin_nxt;
	end

	assign gp_pin_0 = pin_r[0];
	assign gp_pin_1 = pin_r[1];
	assign gp_pin_2 = pin_r[2];
	assign gp_pin_3 = pin_r[3];
	assign gp_pin_4 = pin_r[4];
	assign gp_pin_5 = pin_r[5];

	wire cont_rx = !packet_mode && is_rx;
	wire [1:0] code1 = pin_route_cfg_a[rspr_pkg::CFG_A_PIN1_LSB +: rspr_pkg::CODE_W];
	wire [1:0] code2 = pin_route_cfg_a[rspr_pkg::CFG_A_PIN2_LSB +: rspr_pkg::CODE_W];
	wire [1:0] code3 = pin_route_cfg_a[rspr_pkg::CFG_A_PIN3_LSB +: rspr_pkg::CODE_W];
	wire [1:0] code5 = pin_route_cfg_b[rspr_pkg::CFG_B_PIN5_LSB +: rspr_pkg::CODE_W];
	property p_unmapped_low;
		@(posedge clk) disable iff (srst)
		(!packet_mode && op_state == rspr_pkg::RSPR_SLEEP && code3 == rspr_pkg::CODE_01) |=> !gp_pin_3;
	endproperty
	a_unmapped_low: assert property (p_unmapped_low) else $error("unmapped pin not low");
	property p_cont_data;
		@(posedge clk) disable iff (srst)
		cont_rx |=> (gp_pin_2 == $past(data_src));
	endproperty
	a_cont_data: assert property (p_cont_data) else $error("data pin does not follow stream");
	property p_pkt_window;
		@(posedge clk) disable iff (srst)
		(packet_mode && is_rx && code5 == rspr_pkg::CODE_01 && !win_r) |=> !gp_pin_5;
	endproperty
	a_pkt_window: assert property (p_pkt_window) else $error("packet data outside window");
	property p_raw_no_dclk;
		@(posedge clk) disable iff (srst)
		(cont_rx && !bit_sync_en && code1 == rspr_pkg::CODE_00) |=> !gp_pin_1;
	endproperty
	a_raw_no_dclk: assert property (p_raw_no_dclk) else $error("bit clock driven without synchroniser");
	property p_dclk_low;
		@(posedge clk) disable iff (srst)
		bit_evt |=> (!dclk_r) [*4] ##1 dclk_r;
	endproperty
	a_dclk_low: assert property (p_dclk_low) else $error("bit clock low phase wrong");
	property p_data_on_fall;
		@(posedge clk) disable iff (srst)
		(bit_data_r != $past(bit_data_r)) |-> !dclk_r;
	endproperty
	a_data_on_fall: assert property (p_data_on_fall) else $error("data changed while bit clock high");
	property p_fifo_write;
		@(posedge clk) disable iff (srst)
		(bit_evt && packet_mode && is_rx) |=> (fifo_wr.valid && fifo_wr.bit_value == $past(bit_hold_r));
	endproperty
	a_fifo_write: assert property (p_fifo_write) else $error("received bit not written to queue");
	property p_fifo_idle;
		@(posedge clk) disable iff (srst)
		!packet_mode |=> !fifo_wr.valid;
	endproperty
	a_fifo_idle: assert property (p_fifo_idle) else $error("queue written in continuous mode");
	property p_keep_after_rx;
		@(posedge clk) disable iff (srst)
		(is_rx ##1 !is_rx) |=> !fifo_clear;
	endproperty
	a_keep_after_rx: assert property (p_keep_after_rx) else $error("queue cleared on leaving receive");
	property p_pkt_idle_flags;
		@(posedge clk) disable iff (srst)
		(packet_mode && op_state == rspr_pkg::RSPR_STANDBY && code2 == rspr_pkg::CODE_00)
			|=> (gp_pin_2 == $past(flags.queue_nonempty_flag));
	endproperty
	a_pkt_idle_flags: assert property (p_pkt_idle_flags) else $error("nonempty flag not on pin 2");

endmodule

// ### logic/rspr_pkg.sv
// shared types and constants for the status pin router
package rspr_pkg;

	localparam int NUM_PINS = 6;
	localparam int CODE_W = 2;
	localparam int SRC_W = 5;
	localparam int ROW_W = NUM_PINS * SRC_W;
	localparam int NUM_SRC = 17;

	// code positions inside the two mapping ports
	localparam int CFG_A_PIN0_LSB = 6;
	localparam int CFG_A_PIN1_LSB = 4;
	localparam int CFG_A_PIN2_LSB = 2;
	localparam int CFG_A_PIN3_LSB = 0;
	localparam int CFG_B_PIN4_LSB = 6;
	localparam int CFG_B_PIN5_LSB = 4;

	localparam logic [1:0] CODE_00 = 2'h0;
	localparam logic [1:0] CODE_01 = 2'h1;
	localparam logic [1:0] CODE_10 = 2'h2;
	localparam logic [1:0] CODE_11 = 2'h3;

	// timing of the recovered bit clock low phase after each new bit
	localparam int CLK_PERIOD_PS = 5000;
	localparam int DCLK_LOW_NS = 20;
	localparam int DCLK_LOW_CYC_I = (DCLK_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DCLK_CNT_W = 4;
	localparam logic [DCLK_CNT_W-1:0] DCLK_LOW_CYC = DCLK_CNT_W'(DCLK_LOW_CYC_I);
	localparam logic [DCLK_CNT_W-1:0] DCLK_CNT_ONE = 4'h1;
	localparam logic [DCLK_CNT_W-1:0] DCLK_CNT_ZERO = 4'h0;

	// operating state, gray coded along sleep, standby, synthesizer, receive
	typedef enum logic [1:0] {
		RSPR_SLEEP = 2'h0,
		RSPR_STANDBY = 2'h1,
		RSPR_SYNTHESIZER_STATE = 2'h3,
		RSPR_RECEIVE = 2'h2
	} rspr_state_t;

	typedef enum logic [SRC_W-1:0] {
		SRC_LOW = 5'h00,
		SRC_CLK = 5'h01,
		SRC_TO = 5'h02,
		SRC_RSSI = 5'h03,
		SRC_DATA = 5'h04,
		SRC_DCLK = 5'h05,
		SRC_SYNC = 5'h06,
		SRC_RR = 5'h07,
		SRC_LB = 5'h08,
		SRC_AM = 5'h09,
		SRC_MR = 5'h0A,
		SRC_PLL = 5'h0B,
		SRC_FF = 5'h0C,
		SRC_FNE = 5'h0D,
		SRC_FL = 5'h0E,
		SRC_CRC = 5'h0F,
		SRC_PR = 5'h10
	} rspr_src_t;

	typedef struct packed {
		logic sync_match_flag;
		logic rx_time_limit_flag;
		logic signal_strength_flag;
		logic receiver_ready_flag;
		logic battery_low_flag;
		logic auto_sequencer_active;
		logic op_state_ready;
		logic synth_lock_flag;
		logic queue_full_flag;
		logic queue_nonempty_flag;
		logic queue_level_flag;
		logic checksum_pass_flag;
		logic packet_body_available;
	} rspr_flags_t;

	typedef struct packed {
		logic valid;
		logic bit_value;
	} rspr_fifo_bit_t;

endpackage

// ### logic/rspr_sync2.sv
// two-stage synchroniser for levels and toggles
`timescale 1ns/1ps
module rspr_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		meta_r <= d;
		sync_r <= meta_r;
	end

	assign q = sync_r;

endmodule

// ### bench/rspr_host.sv
// host model that samples recovered data on bit clock rises
`timescale 1ns/1ps
module rspr_host (
	input wire logic data_pin,
	input wire logic bclk_pin,
	output logic rx_bit,
	output int rx_count
);
	initial
	begin
		rx_bit = 1'b0;
		rx_count = 0;
	end
	// data only trusted at the rise, it moves on the fall
	always @(posedge bclk_pin)
	begin
		rx_bit <= data_pin;
		rx_count <= rx_count + 1;
	end
endmodule

// ### bench/tb.sv
// self-checking bench for the status pin router
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("unexpected %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
	typedef struct {int due; logic [5:0] m; logic [5:0] v;} rspr_note_t;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] cfg_a = 8'h00;
	logic [7:0] cfg_b = 8'h00;
	rspr_pkg::rspr_state_t op_state = rspr_pkg::RSPR_SLEEP;
	logic packet_mode = 1'b0;
	logic bit_sync_en = 1'b0;
	rspr_pkg::rspr_flags_t flags = '0;
	logic ref_clock_output = 1'b0;
	logic demod_raw = 1'b0;
	logic demod_bit = 1'b0;
	wire [5:0] pins;
	rspr_pkg::rspr_fifo_bit_t fifo_wr;
	logic fifo_clear;
	logic host_bit;
	int host_count;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	int wr_cnt = 0;
	int one_cnt = 0;
	int clr_cnt = 0;
	int wr0;
	int one0;
	int c0;
	int h0;
	int seed = 32'h95E28331;
	logic [31:0] rnd;
	rspr_pkg::rspr_state_t st_n;
	rspr_pkg::rspr_flags_t fl_n;
	logic [11:0] exp_p;
	logic prev;
	logic exp_bit;
	rspr_note_t note_q[$];
	logic bit_q[$];
	// rows by {packet, receive, code}, pins 5 down to 0; lower case p/c are state gated
	string tbl [16] = '{"c----p", "------", "BBA-BB", "Mp--pM", "CTSDKY", "SRRDRT", "BYADBS", "MPTDYM",
		"c-FNL-", "----F-", "BBBBNB", "MppApp", "CTFNLO", "DSSDFV", "BRYBNY", "MPPATS"};

	rspr_router i_rspr_router (.clk(clk), .srst(srst), .link_clk(link_clk), .pin_route_cfg_a(cfg_a),
		.pin_route_cfg_b(cfg_b), .op_state(op_state), .packet_mode(packet_mode), .bit_sync_en(bit_sync_en),
		.flags(flags), .ref_clock_output(ref_clock_output), .demod_raw(demod_raw), .demod_bit(demod_bit),
		.gp_pin_0(pins[0]), .gp_pin_1(pins[1]), .gp_pin_2(pins[2]), .gp_pin_3(pins[3]), .gp_pin_4(pins[4]),
		.gp_pin_5(pins[5]), .fifo_wr(fifo_wr), .fifo_clear(fifo_clear));
	rspr_host i_rspr_host (.data_pin(pins[2]), .bclk_pin(pins[1]), .rx_bit(host_bit), .rx_count(host_count));

	always #2.5 clk = ~clk;
	initial
	begin
		#13;
		forever #40 link_clk = ~link_clk;
	end

	task wrap_up;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task note(input int d, input logic [5:0] m, input logic [5:0] v);
		rspr_note_t n;
		n.due = cyc + d;
		n.m = m;
		n.v = v;
		note_q.push_back(n);
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// returns {care mask, value}; data and bit clock pins are left to the stream checks
	function automatic logic [11:0] ref_pins(input logic [7:0] a, input logic [7:0] b,
		input rspr_pkg::rspr_state_t st, input logic pm, input rspr_pkg::rspr_flags_t f, input logic ck);
		logic [11:0] r;
		logic [1:0] c;
		byte ch;
		r = 12'hFC0;
		for (int p = 0; p < 6; p++)
		begin
			c = (p < 4) ? a[6 - 2 * p +: 2] : b[14 - 2 * p +: 2];
			ch = tbl[{pm, st == rspr_pkg::RSPR_RECEIVE, c}][5 - p];
			case (ch)
				"C": r[p] = ck;
				"c": r[p] = ck & (st != rspr_pkg::RSPR_SLEEP);
				"T": r[p] = f.rx_time_limit_flag;
				"S": r[p] = f.signal_strength_flag;
				"Y": r[p] = f.sync_match_flag;
				"R": r[p] = f.receiver_ready_flag;
				"B": r[p] = f.battery_low_flag;
				"A": r[p] = f.auto_sequencer_active;
				"M": r[p] = f.op_state_ready;
				"P": r[p] = f.synth_lock_flag;
				"p": r[p] = f.synth_lock_flag & (st == rspr_pkg::RSPR_SYNTHESIZER_STATE);
				"F": r[p] = f.queue_full_flag;
				"N": r[p] = f.queue_nonempty_flag;
				"L": r[p] = f.queue_level_flag;
				"O": r[p] = f.checksum_pass_flag;
				"V": r[p] = f.packet_body_available;
				"D", "K": r[p + 6] = 1'b0;
				default: r[p] = 1'b0;
			endcase
		end
		return r;
	endfunction

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (fifo_wr.valid === 1'b1)
			wr_cnt++;
		if (fifo_wr.valid === 1'b1 && fifo_wr.bit_value === 1'b1)
			one_cnt++;
		if (fifo_clear === 1'b1)
			clr_cnt++;
		// bound well above the roughly 1600 cycles the sequence needs
		if (cyc == 6000)
		begin
			failures++;
			wrap_up();
		end
	end

	always @(posedge clk)
		while (note_q.size() > 0 && note_q[0].due <= cyc)
		begin
			`CHK(pins & note_q[0].m, note_q[0].v)
			void'(note_q.pop_front());
		end

	// the host's sample settles after its own update lands
	always @(posedge pins[1])
	begin
		#1;
		if (bit_q.size() > 0)
		begin
			exp_bit = bit_q.pop_front();
			`CHK(host_bit, exp_bit)
		end
	end

	initial
	begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		tick(2);
		for (int i = 0; i < 400; i++)
		begin
			@(posedge clk);
			rnd = $random(seed);
			st_n = rspr_pkg::rspr_state_t'(rnd[17:16]);
			fl_n = rspr_pkg::rspr_flags_t'(13'($random(seed)));
			cfg_a <= rnd[7:0];
			cfg_b <= rnd[15:8];
			op_state <= st_n;
			packet_mode <= rnd[18];
			bit_sync_en <= rnd[19];
			ref_clock_output <= rnd[20];
			demod_raw <= rnd[21];
			flags <= fl_n;
			exp_p = ref_pins(rnd[7:0], rnd[15:8], st_n, rnd[18], fl_n, rnd[20]);
			note(2, exp_p[11:6], exp_p[5:0]);
		end
		@(posedge clk);
		cfg_a <= 8'h00;
		cfg_b <= 8'h00;
		op_state <= rspr_pkg::RSPR_RECEIVE;
		packet_mode <= 1'b0;
		bit_sync_en <= 1'b0;
		demod_raw <= 1'b0;
		flags <= '0;
		tick(20);
		for (int k = 0; k < 2; k++)
		begin
			demod_raw <= (k == 0);
			note(8, 6'h06, (k == 0) ? 6'h04 : 6'h00);
			tick(12);
		end
		bit_sync_en <= 1'b1;
		wr0 = wr_cnt;
		repeat (3) @(posedge link_clk);
		h0 = host_count;
		for (int k = 0; k < 41; k++)
		begin
			@(posedge link_clk);
			if (k > 0)
				bit_q.push_back(prev);
			rnd = $random(seed);
			prev = rnd[0];
			demod_bit <= prev;
		end
		repeat (2) @(posedge link_clk);
		@(posedge clk);
		`CHK(bit_q.size(), 0)
		`CHK((host_count - h0 > 40) && (host_count - h0 < 46), 1'b1)
		`CHK(wr_cnt - wr0, 0)
		packet_mode <= 1'b1;
		op_state <= rspr_pkg::RSPR_STANDBY;
		cfg_a <= 8'h44;
		cfg_b <= 8'h10;
		@(posedge link_clk);
		demod_bit <= 1'b1;
		tick(10);
		wr0 = wr_cnt;
		one0 = one_cnt;
		c0 = clr_cnt;
		op_state <= rspr_pkg::RSPR_RECEIVE;
		for (int k = 0; k < 4; k++)
		begin
			tick(50);
			note(1, 6'h24, 6'h00);
		end
		tick(2);
		`CHK(clr_cnt - c0, 1)
		`CHK((wr_cnt - wr0 > 10) && (wr_cnt - wr0 < 15), 1'b1)
		`CHK(one_cnt - one0, wr_cnt - wr0)
		flags.receiver_ready_flag <= 1'b1;
		tick(40);
		note(1, 6'h24, 6'h24);
		tick(2);
		flags.packet_body_available <= 1'b1;
		tick(4);
		note(1, 6'h25, 6'h01);
		tick(2);
		op_state <= rspr_pkg::RSPR_STANDBY;
		tick(4);
		wr0 = wr_cnt;
		tick(100);
		`CHK(wr_cnt - wr0, 0)
		`CHK(clr_cnt - c0, 1)
		tick(5);
		wrap_up();
	end
endmodule
